// ==== pkg/sbc_mode_pkg.sv ====
package sbc_mode_pkg;
   // Operating modes, one-hot.
   typedef enum logic [5:0] {
      MODE_RESET   = 6'h01,
      MODE_NREQ    = 6'h02,
      MODE_NORMAL  = 6'h04,
      MODE_STANDBY = 6'h08,
      MODE_STOP    = 6'h10,
      MODE_SLEEP   = 6'h20
   } mode_t;

   // Mode selection codes written by the host.
   localparam logic [1:0] SEL_STANDBY = 2'h0;
   localparam logic [1:0] SEL_NORMAL = 2'h1;
   localparam logic [1:0] SEL_STOP = 2'h2;
   localparam logic [1:0] SEL_SLEEP = 2'h3;

   // Timing: system clock rate and documented times.
   localparam int CLK_HZ = 10_000_000;
   localparam int NREQ_TIMEOUT_MS = 350;
   localparam int NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int WAKE_PULSE_US = 10;
   localparam int WAKE_PULSE_CYC = (WAKE_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int RESET_DUR_TICKS = 64;
   localparam int CYCLIC_ON_TICKS = 4;
   localparam int CYCLIC_OFF_TICKS = 60;
   localparam int WD_PERIOD_TICKS = 1024;
   localparam logic [1:0] OSC_HIGH = 2'h1;
   localparam logic [1:0] OSC_LOW = 2'h2;
endpackage

// ==== pkg/sbc_tick_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Carries oscillator ticks from the oscillator domain to the mode controller.
interface sbc_tick_if;
   logic tick_toggle;
   modport source (output tick_toggle);
   modport sink (input tick_toggle);
endinterface
`default_nettype wire

// ==== rtl/sbc_osc_ticker.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbc_osc_ticker #(
   parameter int HIGH_DIV = 4,
   parameter int LOW_DIV = 8
) (
   // Oscillator domain.
   input wire logic osc_clk,
   input wire logic osc_rst_b,
   // Selected oscillator from the main domain.
   input wire logic use_low_osc,
   // Tick events toward the main domain.
   sbc_tick_if.source ticks
);
   logic sel_meta;
   logic sel_sync;
   logic [7:0] count;
   logic toggle;

   // Two-stage synchroniser for the oscillator selection level.
   always_ff @(posedge osc_clk) begin
      if (!osc_rst_b) begin
         sel_meta <= 1'b0;
         sel_sync <= 1'b0;
      end else begin
         sel_meta <= use_low_osc;
         sel_sync <= sel_meta;
      end
   end

   // The low-power oscillator is modelled as a slower division of the same source.
   always_ff @(posedge osc_clk) begin
      if (!osc_rst_b) begin
         count <= 8'h00;
         toggle <= 1'b0;
      end else if (count >= (sel_sync ? 8'(LOW_DIV - 1) : 8'(HIGH_DIV - 1))) begin
         count <= 8'h00;
         toggle <= ~toggle;
      end else begin
         count <= count + 8'h01;
      end
   end

   assign ticks.tick_toggle = toggle;
endmodule
`default_nettype wire

// ==== rtl/sbc_operating_mode_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbc_operating_mode_controller
   import sbc_mode_pkg::*;
#(
   parameter int RESET_TICKS = sbc_mode_pkg::RESET_DUR_TICKS,
   parameter int NREQ_CYCLES = sbc_mode_pkg::NREQ_TIMEOUT_CYC,
   parameter int WD_TICKS = sbc_mode_pkg::WD_PERIOD_TICKS
) (
   // Clocks and resets.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic osc_clk,
   input wire logic osc_rst_b,
   // Analog comparator levels.
   input wire logic battery_below_3v,
   input wire logic battery_below_6v,
   input wire logic regulator_overtemp,
   input wire logic second_supply_below_4v,
   input wire logic switch_overtemp,
   input wire logic main_undervoltage,
   input wire logic main_overcurrent,
   // Wake sources.
   input wire logic [3:0] wake_inputs,
   input wire logic [3:0] wake_input_enable,
   input wire logic cyclic_sense_enable,
   input wire logic forced_wake_enable,
   input wire logic can_rx_activity,
   input wire logic chip_select_b,
   // Host commands, one-cycle strobes and held levels in the clk domain.
   input wire logic mode_write,
   input wire logic [1:0] mode_select,
   input wire logic watchdog_period_write,
   input wire logic watchdog_clear,
   input wire logic watchdog_closed_window_trigger,
   input wire logic flag_clear,
   input wire logic stop_watchdog_enable,
   input wire logic switch_on_bit,
   input wire logic early_warning_mask,
   // Mode state.
   output sbc_mode_pkg::mode_t mode,
   output logic [1:0] osc_select,
   // Power and pin controls.
   output logic main_regulator_on,
   output logic main_regulator_low_power,
   output logic second_supply_drive,
   output logic high_side_switch,
   output logic can_transmit_enable,
   output logic reset_out_b,
   output logic interrupt_out_b,
   output logic watchdog_running,
   // Status flags.
   output logic battery_fail_flag,
   output logic battery_warning_flag,
   output logic regulator_temp_warning,
   output logic regulator_temp_int_flag,
   output logic second_supply_low_flag,
   output logic switch_overtemp_flag,
   output logic switch_or_supply_fault_flag,
   output logic can_wake_flag,
   output logic [3:0] wake_input_levels
);
   import sbc_mode_pkg::*;

   // Wake pulse length in system clock cycles.
   localparam int PULSE_CYCLES = WAKE_PULSE_CYC;

   // Tick carrier between the oscillator divider and this domain.
   sbc_tick_if tick_bus ();

   mode_t next_mode;
   // Pin synchroniser bits: 4 chip select, 3 over-current, 2 under-voltage, 1 CAN, 0 switch over-temperature.
   logic [4:0] meta;
   logic [4:0] sync;
   logic [3:0] wake_meta;
   logic [3:0] wake_sync;
   logic [3:0] wake_prev;
   logic [2:0] tick_sync;
   logic tick;
   logic cs_prev;
   logic from_sleep;
   logic [15:0] reset_count;
   logic [31:0] nreq_count;
   logic [15:0] wd_count;
   logic [15:0] cyc_count;
   logic cyc_on;
   logic [7:0] pulse_count;
   logic stop_wake;
   logic sleep_wake;
   logic wd_timeout;
   logic reset_cause;

   // Divider in the oscillator domain; only a toggle and a selection level cross between domains.
   sbc_osc_ticker u_ticker (
      .osc_clk(osc_clk),
      .osc_rst_b(osc_rst_b),
      .use_low_osc(osc_select == OSC_LOW),
      .ticks(tick_bus)
   );

   // Pin-level inputs pass two flip-flops; chip select rests high so reset leaves no false rising edge.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta <= 5'h10;
         sync <= 5'h10;
      end else begin
         meta <= {chip_select_b, main_overcurrent, main_undervoltage, can_rx_activity, switch_overtemp};
         sync <= meta;
      end
   end

   // Wake inputs pass two flip-flops; the third stage holds the previous level for change detection.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wake_meta <= 4'h0;
         wake_sync <= 4'h0;
         wake_prev <= 4'h0;
      end else begin
         wake_meta <= wake_inputs;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
      end
   end

   // The oscillator toggle passes two flip-flops; the third stage only serves to see it change.
   always_ff @(posedge clk) begin
      if (!rst_b) tick_sync <= 3'h0;
      else tick_sync <= {tick_sync[1:0], tick_bus.tick_toggle};
   end

   // Synchronised chip select of the previous cycle, for the rising edge that wakes Stop.
   always_ff @(posedge clk) begin
      if (!rst_b) cs_prev <= 1'b1;
      else cs_prev <= sync[4];
   end

   // True in the two host-selected running modes.
   function automatic logic is_running(input mode_t m);
      return m == MODE_NORMAL || m == MODE_STANDBY;
   endfunction

   // True in the two low-power modes, which run from the slow oscillator.
   function automatic logic is_low_power(input mode_t m);
      return m == MODE_SLEEP || m == MODE_STOP;
   endfunction

   assign tick = tick_sync[2] ^ tick_sync[1];
   assign wake_input_levels = wake_sync;

   // Sleep sources shared by Stop; chip select and over-current added in Stop.
   assign sleep_wake = (|((wake_sync ^ wake_prev) & wake_input_enable)) ||
                       (cyclic_sense_enable && cyc_on && tick && |(wake_sync & wake_input_enable)) ||
                       (forced_wake_enable && cyc_on && tick && cyc_count == 16'h0000) ||
                       sync[1];
   assign stop_wake = sleep_wake || (!cs_prev && sync[4]) || sync[3];
   assign wd_timeout = wd_count >= 16'(WD_TICKS);
   // A closed-window trigger only counts while the watchdog runs.
   assign reset_cause = sync[2] || (watchdog_running && wd_timeout) ||
                        (watchdog_running && watchdog_closed_window_trigger);

   // The watchdog runs in Normal, Standby and, by choice, Stop; cleared by host service.
   always_comb begin
      case (mode)
         MODE_NORMAL, MODE_STANDBY: watchdog_running = 1'b1;
         MODE_STOP: watchdog_running = stop_watchdog_enable;
         default: watchdog_running = 1'b0;
      endcase
   end

   // The counter saturates at its limit, so a time-out stays seen until the mode changes.
   always_ff @(posedge clk) begin
      if (!rst_b || !watchdog_running || watchdog_clear) begin
         wd_count <= 16'h0000;
      end else if (tick && !wd_timeout) begin
         wd_count <= wd_count + 16'h0001;
      end
   end

   // Mode sequencing; the host selects Stop, Sleep, Normal and Standby, and a Normal Request time-out after a Sleep wake returns to Sleep.
   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_RESET: begin
            if (reset_count >= 16'(RESET_TICKS)) next_mode = MODE_NREQ;
         end
         MODE_NREQ: begin
            if (sync[2]) next_mode = MODE_RESET;
            else if (watchdog_period_write) next_mode = MODE_NORMAL;
            else if (nreq_count >= 32'(NREQ_CYCLES)) next_mode = from_sleep ? MODE_SLEEP : MODE_RESET;
         end
         MODE_NORMAL, MODE_STANDBY: begin
            if (reset_cause) next_mode = MODE_RESET;
            else if (mode_write) begin
               case (mode_select)
                  SEL_STANDBY: next_mode = MODE_STANDBY;
                  SEL_NORMAL: next_mode = MODE_NORMAL;
                  SEL_STOP: next_mode = MODE_STOP;
                  default: next_mode = MODE_SLEEP;
               endcase
            end
         end
         MODE_STOP: begin
            // A Stop wake skips Reset, so the sleeping processor keeps its state.
            if (reset_cause) next_mode = MODE_RESET;
            else if (stop_wake) next_mode = MODE_NREQ;
         end
         MODE_SLEEP: begin
            if (sleep_wake) next_mode = MODE_RESET;
         end
         default: next_mode = MODE_RESET;
      endcase
   end

   // The single mode register; every supply control and the reset pin are decoded from it.
   always_ff @(posedge clk) begin
      if (!rst_b) mode <= MODE_RESET;
      else mode <= next_mode;
   end

   // Remembers whether Normal Request follows a Sleep wake.
   always_ff @(posedge clk) begin
      if (!rst_b) from_sleep <= 1'b0;
      else if (mode == MODE_SLEEP && next_mode == MODE_RESET) from_sleep <= 1'b1;
      else if (mode == MODE_NREQ && next_mode != MODE_NREQ) from_sleep <= 1'b0;
      else if (mode != MODE_SLEEP && mode != MODE_RESET && mode != MODE_NREQ) from_sleep <= 1'b0;
   end

   // Reset duration counted in oscillator ticks.
   always_ff @(posedge clk) begin
      if (!rst_b || mode != MODE_RESET) reset_count <= 16'h0000;
      else if (tick) reset_count <= reset_count + 16'h0001;
   end

   // Normal Request timeout restarts on each entry.
   // It counts system clock cycles, so it is as accurate as that clock rather than the oscillator.
   always_ff @(posedge clk) begin
      if (!rst_b || mode != MODE_NREQ) nreq_count <= 32'h0000_0000;
      else nreq_count <= nreq_count + 32'h0000_0001;
   end

   // Cyclic timer for switch sensing and forced wake in low-power modes.
   // It restarts in the off phase on every entry, so the first on phase comes a full off time later.
   always_ff @(posedge clk) begin
      if (!rst_b || !is_low_power(mode)) begin
         cyc_count <= 16'h0000;
         cyc_on <= 1'b0;
      end else if (tick) begin
         if (cyc_count >= 16'(cyc_on ? CYCLIC_ON_TICKS - 1 : CYCLIC_OFF_TICKS - 1)) begin
            cyc_count <= 16'h0000;
            cyc_on <= ~cyc_on;
         end else begin
            cyc_count <= cyc_count + 16'h0001;
         end
      end
   end

   // Non-maskable wake pulse after a Stop wake; a pulse extends over the flag logic.
   always_ff @(posedge clk) begin
      if (!rst_b) pulse_count <= 8'h00;
      else if (mode == MODE_STOP && next_mode == MODE_NREQ) pulse_count <= 8'(PULSE_CYCLES);
      else if (pulse_count != 8'h00) pulse_count <= pulse_count - 8'h01;
   end

   // Sticky flags; a fresh event in the clear cycle wins over the clear.
   // One strobe clears them all, so the host must read every flag before it clears.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         battery_fail_flag <= 1'b0;
         battery_warning_flag <= 1'b0;
         regulator_temp_warning <= 1'b0;
         regulator_temp_int_flag <= 1'b0;
         second_supply_low_flag <= 1'b0;
         switch_overtemp_flag <= 1'b0;
         switch_or_supply_fault_flag <= 1'b0;
         can_wake_flag <= 1'b0;
      end else begin
         battery_fail_flag <= battery_below_3v || (battery_fail_flag && !flag_clear);
         battery_warning_flag <= (is_running(mode) && battery_below_6v) ||
                                 (battery_warning_flag && !flag_clear);
         regulator_temp_warning <= regulator_overtemp || (regulator_temp_warning && !flag_clear);
         regulator_temp_int_flag <= regulator_overtemp || (regulator_temp_int_flag && !flag_clear);
         second_supply_low_flag <= second_supply_below_4v || (second_supply_low_flag && !flag_clear);
         switch_overtemp_flag <= sync[0] || (switch_overtemp_flag && !flag_clear);
         switch_or_supply_fault_flag <= sync[0] || second_supply_below_4v ||
                                        (switch_or_supply_fault_flag && !flag_clear);
         can_wake_flag <= (mode != MODE_NORMAL && sync[1]) || (can_wake_flag && !flag_clear);
      end
   end

   // Supply, switch and reset pins decoded from mode; the interrupt pin from the wake pulse and the battery warning.
   // Registering them costs a cycle of delay but keeps decode glitches off the supply controls.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         main_regulator_on <= 1'b1;
         main_regulator_low_power <= 1'b0;
         second_supply_drive <= 1'b0;
         high_side_switch <= 1'b0;
         can_transmit_enable <= 1'b0;
         reset_out_b <= 1'b0;
         interrupt_out_b <= 1'b1;
         osc_select <= OSC_HIGH;
      end else begin
         main_regulator_on <= mode != MODE_SLEEP;
         main_regulator_low_power <= mode == MODE_STOP;
         second_supply_drive <= mode == MODE_NORMAL;
         can_transmit_enable <= mode == MODE_NORMAL;
         reset_out_b <= !(mode == MODE_RESET || mode == MODE_SLEEP);
         interrupt_out_b <= !(pulse_count != 8'h00 ||
                              (battery_warning_flag && !early_warning_mask));
         osc_select <= is_low_power(mode) ? OSC_LOW : OSC_HIGH;
         if (is_running(mode)) high_side_switch <= switch_on_bit && !sync[0];
         else if (is_low_power(mode)) high_side_switch <= cyclic_sense_enable && cyc_on;
         else high_side_switch <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== test/sbc_mode_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbc_mode_chk
   import sbc_mode_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Host strobes and levels.
   input wire logic watchdog_period_write,
   input wire logic watchdog_closed_window_trigger,
   input wire logic switch_on_bit,
   // Mode and pin outputs.
   input var sbc_mode_pkg::mode_t mode,
   input wire logic [1:0] osc_select,
   input wire logic main_regulator_on,
   input wire logic main_regulator_low_power,
   input wire logic second_supply_drive,
   input wire logic high_side_switch,
   input wire logic can_transmit_enable,
   input wire logic reset_out_b,
   input wire logic interrupt_out_b
);
   // Every check runs on the system clock and is quiet while reset is held.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Pin outputs trail the mode by one cycle, so each supply check looks one edge on.
   sequence stop_left;
      mode == MODE_STOP ##1 mode == MODE_NREQ;
   endsequence
   sequence low_osc_mode_held;
      (mode == MODE_STOP || mode == MODE_SLEEP) [*3];
   endsequence
   sequence switch_asked_on;
      ((mode == MODE_NORMAL || mode == MODE_STANDBY) && switch_on_bit) [*3];
   endsequence

   chk_reset_pin_low: assert property (mode == MODE_RESET |=> !reset_out_b)
      else $error("Reset output high during reset mode.");
   chk_nreq_supplies: assert property (mode == MODE_NREQ |=>
      reset_out_b && main_regulator_on && !second_supply_drive)
      else $error("Wrong supplies or reset pin in normal request.");
   chk_period_to_normal: assert property (mode == MODE_NREQ && watchdog_period_write |=> mode == MODE_NORMAL)
      else $error("Period write did not lead to normal mode.");
   chk_normal_supplies: assert property (mode == MODE_NORMAL |=> second_supply_drive && can_transmit_enable)
      else $error("Normal mode lacks second supply or transmit.");
   chk_standby_supplies: assert property (mode == MODE_STANDBY |=>
      main_regulator_on && !second_supply_drive && !can_transmit_enable)
      else $error("Standby supplies or transmit wrong.");
   chk_stop_keep_alive: assert property (mode == MODE_STOP |=> main_regulator_low_power && !second_supply_drive)
      else $error("Stop mode supplies wrong.");
   chk_sleep_all_off: assert property (mode == MODE_SLEEP |=> !main_regulator_on && !second_supply_drive)
      else $error("Regulator left on in sleep mode.");
   chk_low_osc_used: assert property (low_osc_mode_held |-> osc_select == OSC_LOW)
      else $error("High accuracy oscillator kept in a low power mode.");
   chk_switch_follows: assert property (switch_asked_on |-> high_side_switch)
      else $error("Switch not on while its bit is set.");
   chk_window_reset: assert property ((mode == MODE_NORMAL || mode == MODE_STANDBY) &&
      watchdog_closed_window_trigger |=> mode == MODE_RESET)
      else $error("Closed window trigger did not reset.");
   chk_stop_wake_pulse: assert property (stop_left |-> ##[0:3] !interrupt_out_b)
      else $error("No interrupt pulse after stop wake.");
endmodule

bind sbc_operating_mode_controller sbc_mode_chk sbc_mode_chk_inst (.clk, .rst_b, .watchdog_period_write,
   .watchdog_closed_window_trigger, .switch_on_bit, .mode, .osc_select, .main_regulator_on,
   .main_regulator_low_power, .second_supply_drive, .high_side_switch, .can_transmit_enable,
   .reset_out_b, .interrupt_out_b);
`default_nettype wire

// ==== test/host_mcu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model
   import sbc_mode_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Device state and bench controls.
   input var sbc_mode_pkg::mode_t mode,
   input wire logic config_enable,
   input wire logic [7:0] lag,
   // Strobes toward the device.
   output logic watchdog_period_write,
   output logic watchdog_clear
);
   logic [7:0] wait_cnt;
   logic [2:0] clear_cnt;

   // Configures once, lag cycles into normal request; a large lag models a slow host.
   always_ff @(posedge clk) begin
      if (!rst_b || mode != MODE_NREQ) begin
         wait_cnt <= 8'h00;
         watchdog_period_write <= 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 8'h01;
         watchdog_period_write <= config_enable && (wait_cnt == lag);
      end
   end

   // Services the watchdog only in the running modes, never from stop without a wake first.
   always_ff @(posedge clk) begin
      if (!rst_b || !(mode == MODE_NORMAL || mode == MODE_STANDBY)) begin
         clear_cnt <= 3'h0;
         watchdog_clear <= 1'b0;
      end else begin
         clear_cnt <= clear_cnt + 3'h1;
         watchdog_clear <= (clear_cnt == 3'h7);
      end
   end
endmodule
`default_nettype wire

// ==== test/tb_sbc_operating_mode_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_sbc_operating_mode_controller;
   import sbc_mode_pkg::*;
   localparam int NREQ_C = 200;
   // Inputs with their time zero values.
   logic clk = 1'b0, osc_clk = 1'b0, rst_b = 1'b0, osc_rst_b = 1'b0, config_enable = 1'b0;
   logic battery_below_3v = 1'b0, battery_below_6v = 1'b0, regulator_overtemp = 1'b0, second_supply_below_4v = 1'b0;
   logic switch_overtemp = 1'b0, main_undervoltage = 1'b0, main_overcurrent = 1'b0, can_rx_activity = 1'b0;
   logic [3:0] wake_inputs = 4'h0, wake_input_enable = 4'h1;
   logic cyclic_sense_enable = 1'b0, forced_wake_enable = 1'b0, chip_select_b = 1'b1, mode_write = 1'b0;
   logic [1:0] mode_select = 2'h0;
   logic watchdog_closed_window_trigger = 1'b0, flag_clear = 1'b0, stop_watchdog_enable = 1'b0;
   logic switch_on_bit = 1'b0, early_warning_mask = 1'b0, watchdog_period_write, watchdog_clear;
   logic [7:0] lag = 8'h14;
   mode_t mode;
   logic [1:0] osc_select;
   logic main_regulator_on, main_regulator_low_power, second_supply_drive, high_side_switch, can_transmit_enable;
   logic reset_out_b, interrupt_out_b, watchdog_running, battery_fail_flag, battery_warning_flag, can_wake_flag;
   logic regulator_temp_warning, regulator_temp_int_flag, second_supply_low_flag, switch_overtemp_flag;
   logic switch_or_supply_fault_flag;
   logic [3:0] wake_input_levels;
   int num_errors = 0, checked = 0, cycles = 0, n;

   // The oscillator is offset so its edges never line up with the system clock.
   always #50 clk = ~clk;
   initial begin
      #7;
      forever #24 osc_clk = ~osc_clk;
   end

   sbc_operating_mode_controller #(.RESET_TICKS(4), .NREQ_CYCLES(NREQ_C), .WD_TICKS(16))
   sbc_operating_mode_controller_inst (.clk, .rst_b, .osc_clk, .osc_rst_b, .battery_below_3v, .battery_below_6v,
      .regulator_overtemp, .second_supply_below_4v, .switch_overtemp, .main_undervoltage, .main_overcurrent,
      .wake_inputs, .wake_input_enable, .cyclic_sense_enable, .forced_wake_enable, .can_rx_activity, .chip_select_b,
      .mode_write, .mode_select, .watchdog_period_write, .watchdog_clear, .watchdog_closed_window_trigger,
      .flag_clear, .stop_watchdog_enable, .switch_on_bit, .early_warning_mask, .mode, .osc_select,
      .main_regulator_on, .main_regulator_low_power, .second_supply_drive, .high_side_switch, .can_transmit_enable,
      .reset_out_b, .interrupt_out_b, .watchdog_running, .battery_fail_flag, .battery_warning_flag,
      .regulator_temp_warning, .regulator_temp_int_flag, .second_supply_low_flag, .switch_overtemp_flag,
      .switch_or_supply_fault_flag, .can_wake_flag, .wake_input_levels);

   host_mcu_model host_mcu_model_inst (.clk, .rst_b, .mode, .config_enable, .lag, .watchdog_period_write,
      .watchdog_clear);

   // Inputs always move a fixed 5 ns after the rising edge.
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #5;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Bounded wait so a stuck mode is reported rather than hanging the run.
   task automatic wait_mode(input mode_t m, output int k);
      k = 0;
      while (mode !== m && k < 5000) begin
         step(1);
         k++;
      end
      check("mode", mode, m);
   endtask

   task automatic select(input logic [1:0] s);
      mode_select = s;
      mode_write = 1'b1;
      step(1);
      mode_write = 1'b0;
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      step(3);
      rst_b = 1'b1;
      osc_rst_b = 1'b1;
      step(1);
      check("reset pin", reset_out_b, 1'b0);
      wait_mode(MODE_NREQ, n);
      step(2);
      check("nreq pins", {reset_out_b, main_regulator_on, second_supply_drive}, 3'h6);
      check("osc high", osc_select, OSC_HIGH);
      wait_mode(MODE_RESET, n);
      check("nreq timeout", n >= NREQ_C - 2 && n <= NREQ_C + 2, 1'b1);
      config_enable = 1'b1;
      wait_mode(MODE_NREQ, n);
      wait_mode(MODE_NORMAL, n);
      step(2);
      check("normal pins", {second_supply_drive, can_transmit_enable, watchdog_running}, 3'h7);
      for (int v = 1; v >= 0; v--) begin
         switch_on_bit = v[0];
         step(4);
         check("switch", high_side_switch, v[0]);
      end
      {battery_below_3v, battery_below_6v, regulator_overtemp, second_supply_below_4v, switch_overtemp} = 5'h1F;
      can_rx_activity = 1'b1;
      step(5);
      check("battery fail", battery_fail_flag, 1'b1);
      check("battery warn", battery_warning_flag, 1'b1);
      check("temp flags", {regulator_temp_warning, regulator_temp_int_flag}, 2'h3);
      check("supply low", second_supply_low_flag, 1'b1);
      check("switch flags", {switch_overtemp_flag, switch_or_supply_fault_flag}, 2'h3);
      check("can wake normal", can_wake_flag, 1'b0);
      {battery_below_3v, battery_below_6v, regulator_overtemp, second_supply_below_4v, switch_overtemp} = 5'h00;
      step(4);
      flag_clear = 1'b1;
      step(1);
      flag_clear = 1'b0;
      step(2);
      check("flags cleared", {battery_fail_flag, battery_warning_flag, regulator_temp_warning,
         regulator_temp_int_flag, second_supply_low_flag, switch_overtemp_flag, switch_or_supply_fault_flag}, 7'h00);
      wake_inputs = 4'hA;
      select(SEL_STANDBY);
      check("standby", mode, MODE_STANDBY);
      step(4);
      check("standby pins", {main_regulator_on, second_supply_drive, can_transmit_enable}, 3'h4);
      check("can wake", {can_wake_flag, watchdog_running}, 2'h3);
      check("wake levels", wake_input_levels, 4'hA);
      {can_rx_activity, wake_inputs} = 5'h00;
      watchdog_closed_window_trigger = 1'b1;
      select(SEL_NORMAL);
      watchdog_closed_window_trigger = 1'b0;
      check("closed window", mode, MODE_RESET);
      wait_mode(MODE_NORMAL, n);
      select(SEL_STANDBY);
      step(1);
      select(SEL_NORMAL);
      check("standby to normal", mode, MODE_NORMAL);
      step(1);
      select(SEL_STOP);
      check("stop", mode, MODE_STOP);
      step(4);
      check("stop pins", {main_regulator_low_power, second_supply_drive, watchdog_running}, 3'h4);
      check("osc low", osc_select, OSC_LOW);
      stop_watchdog_enable = 1'b1;
      step(1);
      check("stop watchdog", watchdog_running, 1'b1);
      chip_select_b = 1'b0;
      step(2);
      chip_select_b = 1'b1;
      wait_mode(MODE_NREQ, n);
      for (n = 0; interrupt_out_b !== 1'b0 && n < 10; n++) step(1);
      for (n = 0; interrupt_out_b === 1'b0 && n < 500; n++) step(1);
      check("wake pulse", n >= WAKE_PULSE_CYC - 1 && n <= WAKE_PULSE_CYC + 1, 1'b1);
      wait_mode(MODE_NORMAL, n);
      config_enable = 1'b0;
      select(SEL_SLEEP);
      step(3);
      check("sleep pins", {mode == MODE_SLEEP, main_regulator_on, osc_select}, {2'h2, OSC_LOW});
      wake_inputs = 4'h1;
      wait_mode(MODE_RESET, n);
      wake_inputs = 4'h0;
      wait_mode(MODE_NREQ, n);
      wait_mode(MODE_SLEEP, n);
      cyclic_sense_enable = 1'b1;
      for (n = 0; high_side_switch !== 1'b1 && n < 400; n++) step(1);
      check("cyclic switch", n < 400, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
